// ==== grmc_top.sv ====
// Purpose: global request and mode control registers with request event logic
// Assumes: first loop clock domain is sampled as a synchronous tick input
// Notes:   read data valid the cycle after the read strobe
//
// Design decision made here: the strobed register port.
module grmc_top #(
    parameter int HOLD_DEB_CYCLES = grmc_pkg::HOLD_DEB_CYC,
    parameter int HOLD_BYP_CYCLES = grmc_pkg::HOLD_BYP_CYC,
    parameter int RESEED_CYCLES   = grmc_pkg::RESEED_CYC,
    parameter int SLIP_CYCLES     = grmc_pkg::SLIP_CYC
) (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        nrst,
    // register port
    input  wire logic [3:0]  regAddr,
    input  wire logic [7:0]  regWdata,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic      [7:0]  regRdata,
    // loop domain and pins
    input  wire logic        firstLoopTick,
    input  wire logic        holdDebounceEn,
    input  wire logic        general_input_pin,
    // control outputs
    output logic             reseedPulse,
    output logic             pulseGenReq,
    output logic             slipPulse,
    output logic             phaseSyncAlarm,
    output logic             noisePriority,
    output logic             firstLoopHoldover,
    output logic             muteDrivers,
    output logic             restartPulse,
    output logic             sleepMode,
    output logic             autotuneStart,
    output logic             irq
);
    logic [7:0]        mode_q;
    logic [7:0]        aux_q;
    logic [2:0]        irqStat_q;
    logic [2:0]        irqMask_q;
    logic [7:0]        rdata_q;
    grmc_pkg::grmc_rs_t rs_q;
    logic [7:0]        rsCnt_q;
    logic [7:0]        slipCnt_q;
    logic              slipBusy_q;
    logic [3:0]        holdCnt_q;
    logic              holdState_q;
    logic              reseedPulse_q;
    logic              slipPulse_q;
    logic              alarm_q;
    logic              restart_q;
    logic              autotune_q;
    logic              pulseGen_q;

    wire        wrMode    = regWr && (regAddr == grmc_pkg::ADDR_MODE);
    wire        wrAux     = regWr && (regAddr == grmc_pkg::ADDR_AUX);
    wire        wrMask    = regWr && (regAddr == grmc_pkg::ADDR_IRQ_MASK);
    wire        rdStat    = regRd && (regAddr == grmc_pkg::ADDR_IRQ_STAT);
    wire [7:0]  modeNew   = regWdata & grmc_pkg::MODE_WMASK;
    wire [7:0]  auxNew    = regWdata & grmc_pkg::AUX_WMASK;
    // rising edge = written one over stored zero
    wire        reseedRise = wrMode && modeNew[grmc_pkg::BIT_RESEED]
                             && !mode_q[grmc_pkg::BIT_RESEED];
    wire        pulseRise  = wrMode && modeNew[grmc_pkg::BIT_PULSE]
                             && !mode_q[grmc_pkg::BIT_PULSE];
    wire        restartRise = wrMode && modeNew[grmc_pkg::BIT_RESTART]
                             && !mode_q[grmc_pkg::BIT_RESTART];
    wire        slipRise   = wrAux && auxNew[grmc_pkg::BIT_SLIP]
                             && !aux_q[grmc_pkg::BIT_SLIP];
    wire        tuneRise   = wrAux && auxNew[grmc_pkg::BIT_AUTOTUNE]
                             && !aux_q[grmc_pkg::BIT_AUTOTUNE];
    wire        reseedOk   = reseedRise && (rs_q == grmc_pkg::RS_DONE)
                             && !slipBusy_q;
    wire        holdReq    = mode_q[grmc_pkg::BIT_HOLDOVER] || general_input_pin;
    wire [3:0]  holdTarget = holdDebounceEn ? 4'(HOLD_DEB_CYCLES)
                                            : 4'(HOLD_BYP_CYCLES);
    wire        rsFinish   = (rs_q == grmc_pkg::RS_RUN) && (rsCnt_q == 8'd0);
    wire        slipFinish = slipBusy_q && (slipCnt_q == 8'd0);
    wire        holdEnter  = holdReq && !holdState_q && firstLoopTick
                             && (holdCnt_q + 4'd1 == holdTarget);
    wire [2:0]  irqEv;
    assign irqEv[grmc_pkg::IRQ_RESEED_DONE] = rsFinish;
    assign irqEv[grmc_pkg::IRQ_SLIP_ALARM]  = slipFinish;
    assign irqEv[grmc_pkg::IRQ_HOLDOVER]    = holdEnter;
    wire [3:0]  rsCode = (rs_q == grmc_pkg::RS_DONE) ? grmc_pkg::RSYNC_CODE_DONE :
                         (rs_q == grmc_pkg::RS_RUN)  ? grmc_pkg::RSYNC_CODE_RUN  :
                                                       grmc_pkg::RSYNC_CODE_IDLE;
    wire [7:0]  statusWord = {2'b00, alarm_q, holdState_q, rsCode};
    wire [7:0]  rdMux = (regAddr == grmc_pkg::ADDR_MODE)     ? mode_q :
                        (regAddr == grmc_pkg::ADDR_AUX)      ? aux_q :
                        (regAddr == grmc_pkg::ADDR_IRQ_STAT) ? {5'b0, irqStat_q} :
                        (regAddr == grmc_pkg::ADDR_IRQ_MASK) ? {5'b0, irqMask_q} :
                        (regAddr == grmc_pkg::ADDR_STATUS)   ? statusWord :
                                                               grmc_pkg::ZERO8;

    // register storage; restart leaves configuration alone
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            mode_q    <= grmc_pkg::MODE_RESET;
            aux_q     <= grmc_pkg::AUX_RESET;
            irqMask_q <= 3'b000;
            rdata_q   <= grmc_pkg::ZERO8;
        end else begin
            if (wrMode) mode_q <= modeNew;
            if (wrAux) aux_q <= auxNew;
            if (wrMask) irqMask_q <= regWdata[2:0];
            rdata_q <= regRd ? rdMux : grmc_pkg::ZERO8;
        end
    end

    // sticky status: set wins over read clear
    always_ff @(posedge core_clk) begin
        if (!nrst) irqStat_q <= 3'b000;
        else irqStat_q <= (rdStat ? 3'b000 : irqStat_q) | irqEv;
    end

    // resync timer: reseeds sync-enabled dividers, restart returns it to done
    always_ff @(posedge core_clk) begin
        if (!nrst || restart_q) begin
            rs_q    <= grmc_pkg::RS_DONE;
            rsCnt_q <= 8'd0;
        end else begin
            unique case (rs_q)
                grmc_pkg::RS_IDLE: rs_q <= grmc_pkg::RS_DONE;
                grmc_pkg::RS_RUN: begin
                    if (rsCnt_q == 8'd0) rs_q <= grmc_pkg::RS_DONE;
                    else rsCnt_q <= rsCnt_q - 8'd1;
                end
                grmc_pkg::RS_DONE: begin
                    if (reseedOk) begin
                        rs_q    <= grmc_pkg::RS_RUN;
                        rsCnt_q <= 8'(RESEED_CYCLES - 1);
                    end
                end
            endcase
        end
    end

    // slip processing, then phase sync alarm
    always_ff @(posedge core_clk) begin
        if (!nrst || restart_q) begin
            slipBusy_q <= 1'b0;
            slipCnt_q  <= 8'd0;
            alarm_q    <= 1'b0;
        end else if (slipRise && !slipBusy_q) begin
            slipBusy_q <= 1'b1;
            slipCnt_q  <= 8'(SLIP_CYCLES - 1);
            alarm_q    <= 1'b0;
        end else if (slipFinish) begin
            slipBusy_q <= 1'b0;
            alarm_q    <= 1'b1;
        end else if (slipBusy_q) begin
            slipCnt_q <= slipCnt_q - 8'd1;
        end
    end

    // holdover debounce, counted on loop-domain ticks
    always_ff @(posedge core_clk) begin
        if (!nrst || restart_q) begin
            holdCnt_q   <= 4'd0;
            holdState_q <= 1'b0;
        end else if (!holdReq) begin
            holdCnt_q   <= 4'd0;
            holdState_q <= 1'b0;
        end else if (holdEnter) begin
            holdState_q <= 1'b1;
        end else if (firstLoopTick && !holdState_q) begin
            holdCnt_q <= holdCnt_q + 4'd1;
        end
    end

    // one-cycle event pulses
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            reseedPulse_q <= 1'b0;
            slipPulse_q   <= 1'b0;
            restart_q     <= 1'b0;
            autotune_q    <= 1'b0;
            pulseGen_q    <= 1'b0;
        end else begin
            reseedPulse_q <= reseedOk;
            slipPulse_q   <= slipRise && !slipBusy_q;
            restart_q     <= restartRise;
            autotune_q    <= tuneRise;
            pulseGen_q    <= pulseRise;
        end
    end

    // registered outputs
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            noisePriority     <= 1'b0;
            muteDrivers       <= 1'b0;
            sleepMode         <= 1'b0;
            firstLoopHoldover <= 1'b0;
            phaseSyncAlarm    <= 1'b0;
            irq               <= 1'b0;
        end else begin
            noisePriority     <= mode_q[grmc_pkg::BIT_NOISEPRIO];
            muteDrivers       <= mode_q[grmc_pkg::BIT_MUTE];
            sleepMode         <= mode_q[grmc_pkg::BIT_SLEEP];
            firstLoopHoldover <= holdState_q;
            phaseSyncAlarm    <= alarm_q;
            irq               <= |(irqStat_q & irqMask_q);
        end
    end

    assign regRdata    = rdata_q;
    assign reseedPulse = reseedPulse_q;
    assign slipPulse   = slipPulse_q;
    assign restartPulse = restart_q;
    assign autotuneStart = autotune_q;
    assign pulseGenReq = pulseGen_q;
endmodule : grmc_top

// ==== grmc_pkg.sv ====
// Purpose: constants for the global request and mode control block
// Assumes: 8-bit registers on a plain strobe port, one clock domain
// Notes:   offsets 0x1 and 0x2 are printed; the rest are local additions
package grmc_pkg;
    localparam int          AW              = 4;
    localparam int          DW              = 8;
    localparam logic [3:0]  ADDR_MODE       = 4'h1;
    localparam logic [3:0]  ADDR_AUX        = 4'h2;
    localparam logic [3:0]  ADDR_IRQ_STAT   = 4'h4;
    localparam logic [3:0]  ADDR_IRQ_MASK   = 4'h5;
    localparam logic [3:0]  ADDR_STATUS     = 4'h6;
    localparam logic [7:0]  MODE_RESET      = 8'h00;
    localparam logic [7:0]  AUX_RESET       = 8'h00;
    localparam logic [7:0]  MODE_WMASK      = 8'hDF;
    localparam logic [7:0]  AUX_WMASK       = 8'h06;
    // mode register fields
    localparam int          BIT_RESEED      = 7;
    localparam int          BIT_NOISEPRIO   = 6;
    localparam int          BIT_HOLDOVER    = 4;
    localparam int          BIT_MUTE        = 3;
    localparam int          BIT_PULSE       = 2;
    localparam int          BIT_RESTART     = 1;
    localparam int          BIT_SLEEP       = 0;
    // aux register fields
    localparam int          BIT_AUTOTUNE    = 2;
    localparam int          BIT_SLIP        = 1;
    // interrupt status bits
    localparam int          IRQ_RESEED_DONE = 0;
    localparam int          IRQ_SLIP_ALARM  = 1;
    localparam int          IRQ_HOLDOVER    = 2;
    localparam int          IRQ_W           = 3;
    // resync state codes as seen by software
    localparam logic [3:0]  RSYNC_CODE_IDLE = 4'h0;
    localparam logic [3:0]  RSYNC_CODE_RUN  = 4'h1;
    localparam logic [3:0]  RSYNC_CODE_DONE = 4'h2;
    // holdover delays in loop-clock cycles; reseed and slip lengths in core clock cycles
    localparam int          HOLD_DEB_CYC    = 6;
    localparam int          HOLD_BYP_CYC    = 2;
    localparam int          RESEED_CYC      = 4;
    localparam int          SLIP_CYC        = 4;
    localparam logic [7:0]  ZERO8           = 8'h00;
    typedef enum logic [1:0] {RS_IDLE, RS_RUN, RS_DONE} grmc_rs_t;
endpackage : grmc_pkg

// ==== grmc_top_asserts.sv ====
// Purpose: port checks for the request and mode block
// Assumes: default count parameters
// Notes:   shadow copies of both request registers find the edges
module grmc_asserts (
    // clock, reset and register port
    input wire logic       core_clk,
    input wire logic       nrst,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic       regWr,
    // loop side and outputs
    input wire logic       firstLoopTick, holdDebounceEn, general_input_pin,
    input wire logic       reseedPulse, pulseGenReq, slipPulse, phaseSyncAlarm,
    input wire logic       noisePriority, firstLoopHoldover, muteDrivers, restartPulse
);
    logic [7:0] modeQ_q, auxQ_q;
    logic [3:0] tickCnt_q;
    wire        modeWr  = regWr && regAddr == grmc_pkg::ADDR_MODE;
    wire        auxWr   = regWr && regAddr == grmc_pkg::ADDR_AUX;
    wire        holdReq = general_input_pin | modeQ_q[4];
    wire        pgEdge  = modeWr && regWdata[2] && !modeQ_q[2];
    wire        rsEdge  = modeWr && regWdata[1] && !modeQ_q[1];
    wire        slEdge  = auxWr && regWdata[1] && !auxQ_q[1];
    always_ff @(posedge core_clk) begin
        if (!nrst) modeQ_q <= 8'h00;
        else if (modeWr) modeQ_q <= regWdata;
    end
    always_ff @(posedge core_clk) begin
        if (!nrst) auxQ_q <= 8'h00;
        else if (auxWr) auxQ_q <= regWdata;
    end
    // loop ticks seen while holdover is requested
    always_ff @(posedge core_clk) begin
        if (!nrst || !holdReq) tickCnt_q <= 4'h0;
        else if (firstLoopTick && tickCnt_q != 4'hF) tickCnt_q <= tickCnt_q + 4'h1;
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    a_mute_follows: assert property (modeWr |=> ##1 muteDrivers == $past(regWdata[3], 2))
        else $error("mute mismatch");
    a_noise_select: assert property (modeWr |=> ##1 noisePriority == $past(regWdata[6], 2))
        else $error("path select mismatch");
    a_pulse_gen_edge: assert property (pulseGenReq == $past(pgEdge))
        else $error("pulse request mismatch");
    a_restart_edge: assert property (restartPulse == $past(rsEdge))
        else $error("restart mismatch");
    a_slip_edge: assert property (slipPulse == $past(slEdge))
        else $error("slip mismatch");
    a_alarm_after_slip: assert property (slipPulse |-> ##2 !phaseSyncAlarm ##[1:7] phaseSyncAlarm)
        else $error("slip alarm timing");
    a_reseed_busy: assert property (reseedPulse |=> (!reseedPulse) [*4])
        else $error("reseed taken while busy");
    a_hold_delay: assert property ($rose(firstLoopHoldover) |-> $past(tickCnt_q) == (holdDebounceEn ? 4'h6 : 4'h2))
        else $error("holdover delay");
    cover property (slipPulse ##[1:8] phaseSyncAlarm);
    cover property ($rose(firstLoopHoldover));
    cover property (reseedPulse);
endmodule : grmc_asserts
bind grmc_top grmc_asserts u_grmc_asserts (.*);

// ==== test_global_request_mode_control.sv ====
// Purpose: self-checking bench for the request and mode block
// Assumes: default counts, loop ticks drawn at random
// Notes:   pulse outputs are counted and compared per request bit
module test_global_request_mode_control;
    timeunit 1ns;
    timeprecision 1ns;
    logic       core_clk = 1'b0, nrst = 1'b0, regWr = 1'b0, regRd = 1'b0;
    logic       firstLoopTick = 1'b0, holdDebounceEn = 1'b0, general_input_pin = 1'b0;
    logic [3:0] regAddr = 4'h0, ad;
    logic [7:0] regWdata = 8'h00, regRdata, rv, st;
    logic [7:0] pc [5] = '{default: 8'h00};
    logic       reseedPulse, pulseGenReq, slipPulse, phaseSyncAlarm, noisePriority, irq;
    logic       firstLoopHoldover, muteDrivers, restartPulse, sleepMode, autotuneStart;
    int         seed = 18528;
    int         num_errors = 0;
    int         total_checks = 0;
    grmc_top u_grmc_top (.*);
    initial forever #50 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        firstLoopTick <= ($random(seed) % 3) == 0;
        if (nrst) begin
            pc[0] <= pc[0] + 8'(pulseGenReq);
            pc[1] <= pc[1] + 8'(restartPulse);
            pc[2] <= pc[2] + 8'(autotuneStart);
            pc[3] <= pc[3] + 8'(slipPulse);
            pc[4] <= pc[4] + 8'(reseedPulse);
        end
    end
    function automatic logic [7:0] expRead(input logic [3:0] a, input logic [7:0] d);
        if (a == grmc_pkg::ADDR_MODE) return d & grmc_pkg::MODE_WMASK;
        if (a == grmc_pkg::ADDR_AUX) return d & grmc_pkg::AUX_WMASK;
        return 8'h00;
    endfunction : expRead
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        regWr    <= 1'b1;
        regAddr  <= a;
        regWdata <= d;
        @(posedge core_clk);
        regWr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge core_clk);
        regRd   <= 1'b1;
        regAddr <= a;
        @(posedge core_clk);
        regRd <= 1'b0;
        @(negedge core_clk);
        d = regRdata;
    endtask : rd
    task automatic report_and_stop;
        if (num_errors == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        #2000000;
        num_errors++;
        report_and_stop();
    end
    initial begin
        repeat (5) @(posedge core_clk);
        nrst <= 1'b1;
        for (int i = 0; i < 9; i++) begin
            ad = (i % 3 == 2) ? 4'hE : 4'(1 + i % 3);
            rv = (i < 3) ? 8'h00 : 8'($random(seed)) & ((ad == 4'h1) ? 8'hED : 8'hFF);
            if (i >= 3) wr(ad, rv);
            rd(ad, st);
            chk("readback", expRead(ad, rv), st);
        end
        wr(4'h1, 8'h00);
        wr(4'h2, 8'h00);
        for (int i = 0; i < 2; i++) begin
            rv = i ? 8'h00 : 8'h49;
            wr(4'h1, rv);
            repeat (2) @(negedge core_clk);
            chk("levels", {5'h0, rv[6], rv[3], rv[0]}, {5'h0, noisePriority, muteDrivers, sleepMode});
        end
        for (int i = 0; i < 4; i++) begin
            ad = (i < 2) ? 4'h1 : 4'h2;
            rv = (i % 2) ? 8'h02 : 8'h04;
            st = pc[i];
            wr(ad, rv);
            wr(ad, rv);
            wr(ad, 8'h00);
            wr(ad, rv);
            wr(ad, 8'h00);
            repeat (2) @(negedge core_clk);
            chk("request pulses", st + 8'h02, pc[i]);
        end
        for (int i = 0; i < 2; i++) begin
            wr(4'h5, i ? 8'h00 : 8'h02);
            repeat (12) @(negedge core_clk);
            rd(4'h4, rv);
            wr(4'h2, 8'h02);
            for (int k = 0; k < 30 && irq !== 1'b1; k++) @(negedge core_clk);
            chk("irq", i ? 8'h00 : 8'h01, 8'(irq));
            rd(4'h6, rv);
            chk("alarm", 8'h20, rv & 8'h20);
            rd(4'h4, rv);
            chk("irq status", 8'h02, rv & 8'h02);
            repeat (2) @(negedge core_clk);
            chk("irq cleared", 8'h00, 8'(irq));
            wr(4'h2, 8'h00);
        end
        for (int i = 0; i < 2; i++) begin // holdover only, entered by the pin and then by mode bit 4
            @(posedge core_clk);
            holdDebounceEn <= (i == 0);
            if (i == 0) general_input_pin <= 1'b1;
            else wr(4'h1, 8'h10);
            for (int k = 0; k < 200 && firstLoopHoldover !== 1'b1; k++) @(negedge core_clk);
            chk("holdover", 8'h01, 8'(firstLoopHoldover));
            @(posedge core_clk);
            general_input_pin <= 1'b0;
            wr(4'h1, 8'h00);
            repeat (3) @(negedge core_clk);
            chk("holdover left", 8'h00, 8'(firstLoopHoldover));
        end
        rd(4'h6, st);
        chk("resync state", {4'h0, grmc_pkg::RSYNC_CODE_DONE}, {4'h0, st[3:0]});
        rv = pc[4];
        // second rising edge lands while the resync timer still runs
        wr(4'h1, 8'h80);
        wr(4'h1, 8'h00);
        wr(4'h1, 8'h80);
        repeat (2) @(negedge core_clk);
        chk("reseed once", rv + 8'h01, pc[4]);
        report_and_stop();
    end
endmodule : test_global_request_mode_control
